// ---- hdl/suc_defines.svh ----
// Constants of the sensor user configuration register block
// What this block does
// - Reserved bits always read as one and ignore writes.
// - Register holds 0011_1010 after reset.
// - Bits 7 and 0 form the two-bit resolution code.
// - Bit 6 is a read-only supply-low flag.
// - Bit 2 enables the heater and reads back last written value.
// - Command 0xE6 plus data writes; 0xE7 then repeated-start read reads.
// - A register read returns one byte with no checksum.
// - Device answers at seven-bit address 0x40.
`ifndef SUC_DEFINES_SVH
`define SUC_DEFINES_SVH

// ----------------------------------------
// Bus addressing and commands
// ----------------------------------------
`define SUC_DEV_ADDR 7'h40
`define SUC_CMD_WRITE 8'hE6
`define SUC_CMD_READ 8'hE7

// ----------------------------------------
// Register layout
// ----------------------------------------
`define SUC_CFG_RESET 8'h3A
`define SUC_RESERVED_MASK 8'h3A
`define SUC_RES_HI_BIT 7
`define SUC_SUPPLY_BIT 6
`define SUC_HEATER_BIT 2
`define SUC_RES_LO_BIT 0
`define SUC_RES_RESET 2'h0
`define SUC_HEATER_RESET 1'h0

// ----------------------------------------
// Bit counting
// ----------------------------------------
`define SUC_BITS_PER_BYTE 4'h8
`define SUC_LAST_BIT 4'h7

`endif

// ---- hdl/suc_pkg.sv ----
// Types of the sensor user configuration register block
package suc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_CMD,
		ST_CACK,
		ST_WDATA,
		ST_WACK,
		ST_RDATA,
		ST_RACK,
		ST_IGNORE
	} suc_state_t;
endpackage : suc_pkg

// ---- hdl/suc_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module suc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// First stage is read by the second stage only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= '1;
			stable_q <= '1;
		end else begin
			meta_q <= asyncIn;
			stable_q <= meta_q;
		end
	end

	assign syncOut = stable_q;
endmodule : suc_sync
`default_nettype wire

// ---- hdl/suc_config_reg.sv ----
// I2C target holding the sensor user configuration register
`timescale 1ns/1ps
`default_nettype none
`include "suc_defines.svh"
module suc_config_reg
	import suc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sclPin,
	input wire logic sdaPin,
	input wire logic supplyLowPin,
	output logic sdaOut,
	output logic sdaOeN,
	output logic [1:0] resolutionCode,
	output logic heaterEnable,
	output logic supplyLowFlag
);
	// ----------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------
	logic [2:0] pinSync;
	logic sclS;
	logic sdaS;
	logic supS;
	logic sclPrev_q;
	logic sdaPrev_q;

	suc_sync #(.WIDTH(3)) u_sync (
		.clk(clk),
		.reset(reset),
		.asyncIn({~supplyLowPin, sdaPin, sclPin}),
		.syncOut(pinSync)
	);

	assign sclS = pinSync[0];
	assign sdaS = pinSync[1];
	// Supply enters inverted: sync resets to one, so no false low flag
	assign supS = ~pinSync[2];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclPrev_q <= 1'h1;
			sdaPrev_q <= 1'h1;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	wire sclRise = sclS & ~sclPrev_q;
	wire sclFall = ~sclS & sclPrev_q;
	wire startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
	wire stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

	// ----------------------------------------
	// State and register storage
	// ----------------------------------------
	suc_state_t state_q, state_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d;
	logic sdaOeN_q, sdaOeN_d;
	logic readPend_q, readPend_d;
	logic [1:0] res_q;
	logic heater_q;
	logic supplyLow_q;
	logic sdaOut_q;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire byteDone = (bitCnt_q == `SUC_BITS_PER_BYTE);
	wire lastBit = (bitCnt_q == `SUC_LAST_BIT);
	wire addrMatch = (shift_q[7:1] == `SUC_DEV_ADDR);
	wire rwRead = shift_q[0];
	wire cmdWrite = (shift_q == `SUC_CMD_WRITE);
	wire cmdRead = (shift_q == `SUC_CMD_READ);
	wire commit = (state_q == ST_WACK) && sclFall && !stopSeen && !startSeen;
	// Reserved positions forced to one, whatever was written
	wire [7:0] readByte = `SUC_RESERVED_MASK | {res_q[1], supplyLow_q, 3'h0,
		heater_q, 1'h0, res_q[0]};
	// Read address without a prior read command is refused
	wire addrAck = addrMatch && (!rwRead || readPend_q);
	wire cmdAck = cmdWrite || cmdRead;
	wire byteAck = ((state_q == ST_ADDR) && addrAck) ||
		((state_q == ST_CMD) && cmdAck) || (state_q == ST_WDATA);
	wire receiving = (state_q == ST_ADDR) || (state_q == ST_CMD) ||
		(state_q == ST_WDATA);

	// ----------------------------------------
	// Transfer sequencing
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		sdaOeN_d = sdaOeN_q;
		readPend_d = readPend_q;
		if (stopSeen) begin
			state_d = ST_IDLE;
			sdaOeN_d = 1'h1;
			readPend_d = 1'h0;
		end else if (startSeen) begin
			state_d = ST_ADDR;
			bitCnt_d = 4'h0;
			sdaOeN_d = 1'h1;
		end else if (receiving) begin
			if (sclRise && !byteDone) begin
				shift_d = {shift_q[6:0], sdaS};
				bitCnt_d = bitCnt_q + 4'h1;
			end else if (sclFall && byteDone) begin
				if (byteAck) begin
					sdaOeN_d = 1'h0;
					unique case (state_q)
						ST_ADDR: state_d = ST_AACK;
						ST_CMD: state_d = ST_CACK;
						default: state_d = ST_WACK;
					endcase
				end else begin
					state_d = ST_IGNORE;
				end
			end
		end else if (sclFall) begin
			unique case (state_q)
				ST_AACK: begin
					bitCnt_d = 4'h0;
					if (rwRead) begin
						state_d = ST_RDATA;
						shift_d = readByte;
						sdaOeN_d = readByte[7];
					end else begin
						state_d = ST_CMD;
						sdaOeN_d = 1'h1;
					end
				end
				ST_CACK: begin
					bitCnt_d = 4'h0;
					sdaOeN_d = 1'h1;
					readPend_d = cmdRead;
					state_d = cmdWrite ? ST_WDATA : ST_IGNORE;
				end
				ST_WACK: begin
					sdaOeN_d = 1'h1;
					state_d = ST_IGNORE;
				end
				ST_RDATA: begin
					if (lastBit) begin
						state_d = ST_RACK;
						sdaOeN_d = 1'h1;
					end else begin
						shift_d = {shift_q[6:0], 1'h1};
						sdaOeN_d = shift_q[6];
						bitCnt_d = bitCnt_q + 4'h1;
					end
				end
				ST_RACK: begin
					// Single byte only, even if the host acknowledges
					state_d = ST_IGNORE;
					readPend_d = 1'h0;
				end
				ST_IDLE, ST_IGNORE, ST_ADDR, ST_CMD, ST_WDATA: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h0;
			sdaOeN_q <= 1'h1;
			readPend_q <= 1'h0;
			sdaOut_q <= 1'h0;
		end else begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			sdaOeN_q <= sdaOeN_d;
			readPend_q <= readPend_d;
			sdaOut_q <= 1'h0;
		end
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Commit at the end of the data acknowledge, so a stop or start
	// before it leaves the register untouched
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			res_q <= `SUC_RES_RESET;
			heater_q <= `SUC_HEATER_RESET;
			supplyLow_q <= 1'h0;
		end else begin
			supplyLow_q <= supS;
			if (commit) begin
				res_q <= {shift_q[`SUC_RES_HI_BIT], shift_q[`SUC_RES_LO_BIT]};
				heater_q <= shift_q[`SUC_HEATER_BIT];
			end
		end
	end

	assign sdaOut = sdaOut_q;
	assign sdaOeN = sdaOeN_q;
	assign resolutionCode = res_q;
	assign heaterEnable = heater_q;
	assign supplyLowFlag = supplyLow_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reserved_ones: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_AACK && sclFall && rwRead && !startSeen && !stopSeen)
		|=> (shift_q & `SUC_RESERVED_MASK) == `SUC_RESERVED_MASK)
		else $error("reserved bits not read as one");

	a_reset_value: assert property (@(posedge clk) disable iff (reset)
		$fell(reset) |-> (readByte == (`SUC_CFG_RESET | {1'h0, supplyLow_q,
		6'h0})))
		else $error("register not at reset value");

	a_resolution_load: assert property (@(posedge clk) disable iff (reset)
		commit |=> resolutionCode == {$past(shift_q[`SUC_RES_HI_BIT]),
		$past(shift_q[`SUC_RES_LO_BIT])})
		else $error("resolution code not loaded");

	a_supply_flag: assert property (@(posedge clk) disable iff (reset)
		supS ##1 supS |-> supplyLowFlag && readByte[`SUC_SUPPLY_BIT])
		else $error("supply flag does not follow pin");

	a_heater_load: assert property (@(posedge clk) disable iff (reset)
		commit |=> heaterEnable == $past(shift_q[`SUC_HEATER_BIT]))
		else $error("heater bit not loaded");

	a_single_byte: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_RACK && sclFall && !startSeen && !stopSeen)
		|=> state_q == ST_IGNORE && sdaOeN)
		else $error("data driven after the read byte");

	a_address_nack: assert property (@(posedge clk) disable iff (reset)
		(state_q == ST_ADDR && byteDone && sclFall && !addrMatch &&
		!startSeen && !stopSeen) |=> state_q == ST_IGNORE && sdaOeN)
		else $error("foreign address acknowledged");

	a_write_only_commit: assert property (@(posedge clk) disable iff (reset)
		!commit |=> $stable(heaterEnable) && $stable(resolutionCode))
		else $error("register changed outside a commit");
endmodule : suc_config_reg
`default_nettype wire

// ---- tb/suc_host_model.sv ----
// I2C host model issuing register commands
`timescale 1ns/1ps
`default_nettype none
module suc_host_model (
	input wire logic clk,
	input wire logic sdaIn,
	output var logic scl,
	output var logic sdaLow
);
	// ----------------------------------------
	// Bit level, six clocks a phase
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : w
	// Holds data six clocks past the fall, above the device's need
	task automatic bitIo(input logic b, output logic s);
		sdaLow = ~b;
		w(6);
		scl = 1'b1;
		w(3);
		s = sdaIn;
		w(3);
		scl = 1'b0;
		w(6);
	endtask : bitIo
	task automatic start();
		sdaLow = 1'b0;
		w(6);
		scl = 1'b1;
		w(6);
		sdaLow = 1'b1;
		w(6);
		scl = 1'b0;
		w(6);
	endtask : start
	task automatic stop();
		sdaLow = 1'b1;
		w(6);
		scl = 1'b1;
		w(6);
		sdaLow = 1'b0;
		w(6);
	endtask : stop
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) bitIo(d[i], q[i]);
	endtask : xfer
	// ----------------------------------------
	// Register commands, config register only
	// ----------------------------------------
	task automatic wrReg(input logic [7:0] d, output logic [2:0] a);
		logic [8:0] q;
		start();
		xfer(9'h101, q);
		a[2] = ~q[0];
		xfer({8'hE6, 1'b1}, q);
		a[1] = ~q[0];
		xfer({d, 1'b1}, q);
		a[0] = ~q[0];
		stop();
	endtask : wrReg
	task automatic rdReg(output logic [7:0] d, output logic [2:0] a);
		logic [8:0] q;
		start();
		xfer(9'h101, q);
		a[2] = ~q[0];
		xfer({8'hE7, 1'b1}, q);
		a[1] = ~q[0];
		start();
		xfer(9'h103, q);
		a[0] = ~q[0];
		xfer(9'h1FF, q);
		d = q[8:1];
		stop();
	endtask : rdReg
endmodule : suc_host_model
`default_nettype wire

// ---- tb/sensor_user_config_register_tb.sv ----
// Self-checking bench of the user configuration register
`timescale 1ns/1ps
`default_nettype none
module sensor_user_config_register_tb;
	logic clk, reset, supplyLowPin, sdaOut, sdaOeN, heaterEnable;
	logic supplyLowFlag, scl, sdaLow, s;
	logic [1:0] resolutionCode;
	logic [2:0] a;
	logic [7:0] v, d, e;
	logic [8:0] q;
	int nErrors = 0, nChecks = 0, cyc = 0;
	wire sda;
	wire [7:0] outs = {4'h0, resolutionCode, heaterEnable, supplyLowFlag};
	// Pull-up wins unless a party pulls low
	assign sda = sdaLow ? 1'b0 : (sdaOeN ? 1'b1 : sdaOut);
	suc_config_reg uut (.clk(clk), .reset(reset), .sclPin(scl), .sdaPin(sda),
		.supplyLowPin(supplyLowPin), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.resolutionCode(resolutionCode), .heaterEnable(heaterEnable),
		.supplyLowFlag(supplyLowFlag));
	suc_host_model host (.clk(clk), .sdaIn(sda), .scl(scl), .sdaLow(sdaLow));
	// ----------------------------------------
	// Checks and reporting
	// ----------------------------------------
	task automatic chk8(input string n, input logic [7:0] x,
		input logic [7:0] g);
		nChecks++;
		if (g !== x) begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask : chk8
	task automatic chk1(input string n, input logic x, input logic g);
		chk8(n, {7'h0, x}, {7'h0, g});
	endtask : chk1
	task automatic rdExp(input logic [7:0] x);
		host.rdReg(v, a);
		chk8("readAcks", 8'h07, {5'h0, a});
		chk8("readData", x, v);
	endtask : rdExp
	task automatic finishTest();
		$display("checks %0d mismatches %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finishTest
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run needs about 13400 clocks
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			nErrors++;
			finishTest();
		end
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		supplyLowPin = 1'b0;
		repeat (8) @(posedge clk);
		#2;
		reset = 1'b0;
		host.w(4);
		chk8("outputs", 8'h00, outs);
		rdExp(8'h3A);
		$display("test reset done");
		host.wrReg(8'h40, a);
		chk8("writeAcks", 8'h07, {5'h0, a});
		rdExp(8'h3A);
		$display("test reserved done");
		for (int c = 0; c < 4; c++) begin
			host.rdReg(v, a);
			d = {c[1], v[6:3], ^c[1:0], v[1], c[0]};
			host.wrReg(d, a);
			e = (d & 8'h85) | 8'h3A;
			rdExp(e);
			chk8("resolution", {6'h0, c[1:0]}, {6'h0, resolutionCode});
			chk1("heater", ^c[1:0], heaterEnable);
		end
		$display("test fields done");
		supplyLowPin = 1'b1;
		host.w(10);
		chk1("supplyFlag", 1'b1, supplyLowFlag);
		rdExp(8'hFB);
		$display("test supply done");
		host.start();
		host.xfer(9'h101, q);
		host.xfer({8'hE6, 1'b1}, q);
		// Stop before the eighth data bit; later the device holds the ack
		for (int i = 0; i < 7; i++) host.bitIo(1'b0, s);
		host.stop();
		rdExp(8'hFB);
		$display("test abort done");
		host.start();
		host.xfer(9'h105, q);
		chk1("wrongAddrAck", 1'b1, q[0]);
		host.stop();
		rdExp(8'hFB);
		$display("test address done");
		reset = 1'b1;
		host.w(2);
		reset = 1'b0;
		host.w(4);
		chk8("resetOutputs", 8'h01, outs);
		rdExp(8'h7A);
		chk1("sdaOut", 1'b0, sdaOut);
		$display("test second reset done");
		finishTest();
	end
endmodule : sensor_user_config_register_tb
`default_nettype wire
